// File: bus_sizing_pkg.sv
// Constants for the reduced-pin external bus sizing logic.
// Assumes a 16-bit external data bus and a word-only acknowledge.
package bus_sizing_pkg;
  // Transfer size codes driven on the size pins
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // Request size encoding on the internal side
  localparam logic [1:0] REQ_BYTE = 2'h1;
  localparam logic [1:0] REQ_WORD = 2'h2;
  localparam logic [1:0] REQ_LONG = 2'h0;
  // Core variants
  localparam logic CORE_32 = 1'h0;
  localparam logic CORE_16 = 1'h1;
  // Read value of the freed discrete bit when it is an input
  localparam logic FREED_BIT_READ = 1'h1;
  // Bus sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CYCLE = 4'h2,
    ST_DONE = 4'h4,
    ST_ERR = 4'h8
  } seq_state_t;
endpackage : bus_sizing_pkg

// File: lane_if.sv
// Interface carrying one bus cycle's lane plan between sequencer and lane unit.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface lane_if;
  logic [1:0] size_code; // Size code of the cycle
  logic lowest_address_bit; // Lowest address bit of the cycle
  logic [7:0] byte_a; // Operand byte for the upper lane
  logic [7:0] byte_b; // Operand byte for the lower lane
  logic [15:0] wdata; // Placed write data
  modport seq (output size_code, output lowest_address_bit, output byte_a, output byte_b, input wdata);
  modport lane (input size_code, input lowest_address_bit, input byte_a, input byte_b, output wdata);
endinterface : lane_if

// File: lane_mux.sv
// Byte lane placement for writes to a 16-bit port.
// Assumes the sequencer presents the bytes in operand order.
`timescale 1ns/10ps
module lane_mux
  import bus_sizing_pkg::*;
(
  // Lane plan
  lane_if.lane lp
);
  // Place operand bytes on the lanes, duplicating single bytes
  always_comb
  begin
    if (lp.size_code == SIZE_BYTE || lp.lowest_address_bit)
    begin
      // Single byte on its lane, copied to the other one
      lp.wdata = {lp.byte_a, lp.byte_a}; // [R8] [R9] [R11] [R13]
    end
    else
    begin
      // Two bytes: first upper, second lower
      lp.wdata = {lp.byte_a, lp.byte_b}; // [R10] [R12]
    end
  end
endmodule : lane_mux

// File: bus_sizing.sv
// Reduced pin-count external bus sizing sequencer: splits operands into
// word-port cycles. Assumes the outside device acknowledges on the word ack.
`timescale 1ns/10ps
// Behaviour
// [R1] Outside device always answers with word ack
// [R2] Every acknowledged cycle treated as word port
// [R3] Full parts: outside acks matching its size
// [R4] Freed discrete input bit reads one
// [R5] Drive controls, place and take byte lanes
// [R6] Word ports need fully expanded bus
// [R7] Only 16-bit port cases supported
// [R8] Even byte: size 01, upper lane, duplicated
// [R9] Odd byte: size 01, lower lane, duplicated
// [R10] Aligned word: size 10, one cycle
// [R11] Misaligned word: odd byte then even byte
// [R12] Aligned long: size 00, then word cycle
// [R13] Misaligned long: starts with odd byte cycle
// [R14] 32-bit core: misaligned transfers refused
// [R15] 16-bit core: misaligned long as two words; here three cycles: odd byte, word, even byte
// [R16] Internal chip select ack needs no external
// [R17] Sample word ack on clock, end cycle
module bus_sizing
  import bus_sizing_pkg::*;
#(
  parameter int ADDR_W = 24
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Configuration
  input wire logic core_variant,
  input wire logic bus_full_width,
  // Internal request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic req_ready,
  output logic done_pulse,
  output logic err_pulse,
  output logic [31:0] rdata,
  // External bus
  output logic cycle_active,
  output logic bus_write,
  output logic [1:0] transfer_size_code,
  output logic [ADDR_W-1:0] bus_addr,
  output logic [15:0] bus_wdata,
  output logic bus_wdata_oe,
  input wire logic [15:0] bus_rdata,
  input wire logic word_port_ack_n,
  // Internal chip select acknowledge
  input wire logic cs_ack,
  // Freed discrete bit
  input wire logic ack_pin_discrete,
  input wire logic ack_pin_dir_out,
  input wire logic ack_latch_bit,
  output logic ack_shared_discrete_bit
);
  seq_state_t state_q; // Sequencer state
  logic [ADDR_W-1:0] addr_q; // Address of current cycle
  logic [2:0] left_q; // Operand bytes still to move
  logic [31:0] op_q; // Operand, next byte in top
  logic [31:0] rd_q; // Gathered read bytes
  logic write_q; // Direction of the transfer
  logic ack_seen; // Cycle ended this clock
  logic [1:0] cyc_size; // Size code of this cycle
  logic [2:0] cyc_bytes; // Bytes moved by this cycle
  logic [2:0] req_bytes; // Bytes in the request
  logic misaligned; // Request is misaligned
  lane_if lp();

  // Lane unit builds the write lanes
  lane_mux u_lane
  (
    .lp(lp)
  );

  // Bytes in the requested operand
  always_comb
  begin
    unique case (req_size)
      REQ_BYTE: req_bytes = 3'h1;
      REQ_WORD: req_bytes = 3'h2;
      default: req_bytes = 3'h4;
    endcase
  end

  // Misaligned word or long
  assign misaligned = req_addr[0] && (req_size != REQ_BYTE);

  // Size code and byte count for the current cycle
  always_comb
  begin
    if (addr_q[0])
    begin
      // Odd address moves one byte on the lower lane
      cyc_bytes = 3'h1; // [R11] [R13]
      cyc_size = (left_q == 3'h1) ? SIZE_BYTE : SIZE_WORD; // [R9] [R13]
    end
    else if (left_q == 3'h1)
    begin
      cyc_bytes = 3'h1; // [R8]
      cyc_size = SIZE_BYTE;
    end
    else
    begin
      cyc_bytes = 3'h2; // [R10] [R12]
      cyc_size = (left_q == 3'h4) ? SIZE_LONG : SIZE_WORD;
    end
  end

  // Lane plan: operand bytes come from the top of the shift register
  assign lp.size_code = cyc_size;
  assign lp.lowest_address_bit = addr_q[0];
  assign lp.byte_a = op_q[31:24];
  assign lp.byte_b = op_q[23:16];

  // Cycle ends on sampled word ack or internal chip select ack
  assign ack_seen = (state_q == ST_CYCLE) && (!word_port_ack_n || cs_ack); // [R2] [R17] [R16]

  // Sequencer
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      addr_q <= '0;
      left_q <= 3'h0;
      op_q <= 32'h0;
      write_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (req_valid)
          begin
            // Word port cases need full bus; 32-bit core refuses misaligned
            if (!bus_full_width || (misaligned && core_variant == CORE_32)) // [R6] [R7] [R14]
              state_q <= ST_ERR;
            else
            begin
              state_q <= ST_CYCLE;
              addr_q <= req_addr;
              left_q <= req_bytes;
              write_q <= req_write;
              // Left-justify the operand so its first byte is on top
              unique case (req_size)
                REQ_BYTE: op_q <= {req_wdata[7:0], 24'h0};
                REQ_WORD: op_q <= {req_wdata[15:0], 16'h0};
                default: op_q <= req_wdata;
              endcase
            end
          end
        end
        ST_CYCLE:
        begin
          if (ack_seen)
          begin
            // Step past the bytes just moved; a follow-on cycle continues
            addr_q <= addr_q + ADDR_W'(cyc_bytes); // [R11] [R12] [R15]
            left_q <= left_q - cyc_bytes;
            op_q <= (cyc_bytes == 3'h1) ? {op_q[23:0], 8'h0} : {op_q[15:0], 16'h0};
            if (left_q == cyc_bytes)
              state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        ST_ERR: state_q <= ST_IDLE;
      endcase
    end
  end

  // Read byte gathering from the lanes the cycle uses
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rd_q <= 32'h0;
    else if (state_q == ST_IDLE && req_valid)
      rd_q <= 32'h0;
    else if (ack_seen && !write_q)
    begin
      if (cyc_bytes == 3'h2)
        rd_q <= {rd_q[15:0], bus_rdata}; // [R5] [R10] [R12]
      else if (addr_q[0])
        rd_q <= {rd_q[23:0], bus_rdata[7:0]}; // [R9] [R11]
      else
        rd_q <= {rd_q[23:0], bus_rdata[15:8]}; // [R8]
    end
  end

  // Registered read data and write lanes
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rdata <= 32'h0;
      bus_wdata <= 16'h0;
    end
    else
    begin
      if (state_q == ST_DONE)
        rdata <= rd_q;
      bus_wdata <= lp.wdata; // [R5]
    end
  end

  // Bus controls from the current cycle
  assign cycle_active = (state_q == ST_CYCLE); // [R5]
  assign bus_write = write_q;
  assign bus_wdata_oe = (state_q == ST_CYCLE) && write_q;
  assign transfer_size_code = cyc_size;
  assign bus_addr = addr_q;
  assign req_ready = (state_q == ST_IDLE);
  assign done_pulse = (state_q == ST_DONE);
  assign err_pulse = (state_q == ST_ERR);

  // Freed discrete bit reads one when it is an input
  assign ack_shared_discrete_bit = (ack_pin_discrete && !ack_pin_dir_out) ?
    FREED_BIT_READ : ack_latch_bit; // [R4]
endmodule : bus_sizing

// File: bus_sizing_props.sv
// Checker for the bus sizing block, bound to its top ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module bus_sizing_props
  import bus_sizing_pkg::*;
#(
  parameter int ADDR_W = 24
)
(
  // Clock, reset, configuration
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic core_variant,
  input wire logic bus_full_width,
  // Request side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic done_pulse,
  input wire logic err_pulse,
  // Bus side
  input wire logic cycle_active,
  input wire logic bus_write,
  input wire logic [1:0] transfer_size_code,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wdata_oe,
  input wire logic word_port_ack_n,
  input wire logic cs_ack,
  // Freed discrete bit
  input wire logic ack_pin_discrete,
  input wire logic ack_pin_dir_out,
  input wire logic ack_latch_bit,
  input wire logic ack_shared_discrete_bit
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Request taken this edge
  logic take;
  assign take = req_valid && req_ready;
  a_byte_size: assert property (take && bus_full_width && req_size == REQ_BYTE |=> cycle_active && transfer_size_code == SIZE_BYTE) else $error("byte size code");
  a_long_first: assert property (take && bus_full_width && req_size == REQ_LONG && !req_addr[0] |=> transfer_size_code == SIZE_LONG) else $error("long size code");
  a_width_refuse: assert property (take && !bus_full_width |=> err_pulse && !cycle_active) else $error("narrow bus taken");
  a_mis_refuse: assert property (take && bus_full_width && core_variant == CORE_32 && req_size != REQ_BYTE && req_addr[0] |=> err_pulse) else $error("misaligned taken");
  a_done_ack: assert property (done_pulse |-> $past(!word_port_ack_n || cs_ack)) else $error("done without ack");
  a_freed_bit: assert property (ack_shared_discrete_bit == ((ack_pin_discrete && !ack_pin_dir_out) ? FREED_BIT_READ : ack_latch_bit)) else $error("freed bit");
  a_byte_lanes: assert property (take && bus_full_width && req_write && req_size == REQ_BYTE |=> ##1 bus_wdata == {2{$past(req_wdata[7:0], 2)}}) else $error("byte lanes");
  a_drive_dir: assert property (bus_wdata_oe == (cycle_active && bus_write)) else $error("data enable");
  a_busy_ready: assert property (cycle_active |-> !req_ready) else $error("ready while busy");
  c_refuse: cover property (err_pulse);
  c_long: cover property (transfer_size_code == SIZE_LONG && cycle_active);
  c_done: cover property (done_pulse && bus_write);
endmodule : bus_sizing_props
bind bus_sizing bus_sizing_props #(.ADDR_W(ADDR_W)) u_props (.*);

// File: ext_word_port.sv
// External 16-bit port model: always answers with the word ack.
// Assumes the block holds its bus outputs until the ack edge.
`timescale 1ns/10ps
module ext_word_port
(
  // Clock and bus
  input wire logic ref_clk,
  input wire logic cycle_active,
  input wire logic [23:0] bus_addr,
  // Wait states before ack
  input wire logic [3:0] dly,
  // Answer
  output logic word_port_ack_n = 1'b1,
  output logic [15:0] bus_rdata
);
  int cnt = 0; // Wait counter
  logic [15:0] last = 16'h0; // Last driven lanes
  // Word ack after dly waits, one clock wide
  always @(posedge ref_clk)
  begin
    cnt <= (!cycle_active || !word_port_ack_n) ? 0 : cnt + 1;
    word_port_ack_n <= !(cycle_active && word_port_ack_n && cnt >= dly);
    if (cycle_active)
      last <= bus_rdata;
  end
  // Lanes follow the address; inverted garbage when idle
  assign bus_rdata = cycle_active ? {bus_addr[7:0], ~bus_addr[7:0]} : ~last;
endmodule : ext_word_port

// File: bus_sizing_tb.sv
// Self-checking bench for the bus sizing block against a word port.
// Assumes the partner model in ext_word_port.sv.
`timescale 1ns/10ps
`define CHK(a, b) check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end
module bus_sizing_tb;
  import bus_sizing_pkg::*;
  logic ref_clk = 0, rst_n = 0, core_variant = CORE_16, bus_full_width = 1;
  logic req_valid = 0, req_write = 0, req_ready, done_pulse, err_pulse;
  logic [1:0] req_size = 0, transfer_size_code;
  logic [23:0] req_addr = 0, bus_addr;
  logic [31:0] req_wdata = 0, rdata;
  logic cycle_active, bus_write, bus_wdata_oe, word_port_ack_n, bit_out;
  logic [15:0] bus_wdata, bus_rdata, log_w[4];
  logic [1:0] log_s[4];
  logic [7:0] log_a[4];
  logic disc = 0, dir = 0, latch = 0, cs = 0;
  logic [3:0] dly = 2;
  int n = 0, n_errors = 0, check_count = 0;
  bus_sizing dut (.ref_clk(ref_clk), .rst_n(rst_n), .core_variant(core_variant),
    .bus_full_width(bus_full_width), .req_valid(req_valid), .req_write(req_write),
    .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .done_pulse(done_pulse), .err_pulse(err_pulse), .rdata(rdata),
    .cycle_active(cycle_active), .bus_write(bus_write), .transfer_size_code(transfer_size_code),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wdata_oe(bus_wdata_oe),
    .bus_rdata(bus_rdata), .word_port_ack_n(word_port_ack_n), .cs_ack(cs),
    .ack_pin_discrete(disc), .ack_pin_dir_out(dir), .ack_latch_bit(latch),
    .ack_shared_discrete_bit(bit_out));
  ext_word_port peer (.ref_clk(ref_clk), .cycle_active(cycle_active), .bus_addr(bus_addr),
    .dly(dly), .word_port_ack_n(word_port_ack_n), .bus_rdata(bus_rdata));
  // Clock
  initial forever #12.5 ref_clk = ~ref_clk;
  // Log each bus cycle ended by the word ack
  always @(posedge ref_clk)
    if (cycle_active && !word_port_ack_n)
    begin
      log_w[n] <= bus_wdata;
      log_s[n] <= transfer_size_code;
      log_a[n] <= bus_addr[7:0];
      n <= n + 1;
    end
  // Verdict and stop
  task end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // One request, bounded wait for done or refusal
  task go(input logic w, input logic [1:0] s, input logic [23:0] a, input logic [31:0] d);
    int i;
    @(negedge ref_clk);
    n = 0;
    {req_valid, req_write, req_size, req_addr, req_wdata} = {1'b1, w, s, a, d};
    @(negedge ref_clk);
    req_valid = 0;
    for (i = 0; i < 60 && !done_pulse && !err_pulse; i++)
      @(negedge ref_clk);
    if (i == 60)
    begin
      n_errors++;
      end_sim;
    end
    @(negedge ref_clk);
  endtask : go
  initial
  begin
    repeat (20) @(negedge ref_clk);
    `CHK(req_ready, 1'b1)
    rst_n = 1;
    go(1, REQ_BYTE, 24'h50, 32'h5a); `CHK({n, log_s[0], log_w[0]}, {32'd1, SIZE_BYTE, 16'h5a5a})
    go(1, REQ_BYTE, 24'h51, 32'h3c); `CHK({n, log_w[0]}, {32'd1, 16'h3c3c})
    dly = 0;
    go(0, REQ_BYTE, 24'h31, 32'h0); `CHK(rdata[7:0], 8'hce)
    go(0, REQ_WORD, 24'h10, 32'h0); `CHK({n, log_s[0], rdata[15:0]}, {32'd1, SIZE_WORD, 16'h10ef})
    go(0, REQ_LONG, 24'h20, 32'h0); `CHK({n, log_s[0], log_s[1], rdata}, {32'd2, SIZE_LONG, SIZE_WORD, 32'h20df22dd})
    dly = 2;
    go(1, REQ_WORD, 24'h41, 32'habcd); `CHK({n, log_s[0], log_w[0], log_a[1], log_w[1]}, {32'd2, SIZE_WORD, 16'habab, 8'h42, 16'hcdcd})
    go(1, REQ_LONG, 24'h61, 32'h11223344); `CHK({n, log_w[0], log_w[1], log_w[2], log_a[2]}, {32'd3, 16'h1111, 16'h2233, 16'h4444, 8'h64})
    // Internal chip select ends the cycle before the slow port answers
    cs = 1;
    dly = 15;
    go(0, REQ_WORD, 24'h10, 32'h0); `CHK({n, rdata[15:0]}, {32'd0, 16'h10ef})
    cs = 0;
    dly = 2;
    core_variant = CORE_32;
    go(1, REQ_WORD, 24'h41, 32'h1); `CHK(n, 0)
    bus_full_width = 0;
    go(0, REQ_BYTE, 24'h40, 32'h0); `CHK(n, 0)
    for (int i = 0; i < 8; i++)
    begin
      {disc, dir, latch} = i[2:0];
      @(negedge ref_clk);
      `CHK(bit_out, (disc && !dir) ? 1'b1 : latch)
    end
    end_sim;
  end
endmodule : bus_sizing_tb
